/* common/pit_pkg.sv */
package pit_pkg;

  // Clock and tick timing.
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned BASE_PERIOD_NS  = 1_000_000;
  localparam int unsigned BASE_CYCLES     = (BASE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PRE_W           = 17;
  localparam int unsigned DECADE          = 10;
  localparam logic [3:0]  DECADE_LAST     = 4'h9;

  // Programmed-I/O addressing of this timer.
  localparam logic [5:0]  OWN_DEV_CODE    = 6'h0C;
  localparam int unsigned MASK_BIT_NUM    = 13;
  localparam int unsigned MASK_BIT_POS    = 15 - MASK_BIT_NUM;

  // Avalon register map, byte addresses.
  localparam int unsigned ADDR_W          = 5;
  localparam logic [4:0]  OFS_CMD         = 5'h00;
  localparam logic [4:0]  OFS_STATUS      = 5'h04;
  localparam logic [4:0]  OFS_MASK_OUT    = 5'h08;
  localparam logic [4:0]  OFS_EVT_STATUS  = 5'h0C;
  localparam logic [4:0]  OFS_EVT_MASK    = 5'h10;

  // Reset values.
  localparam logic [1:0]  RATE_RST        = 2'h0;
  localparam logic [15:0] MASK_OUT_RST    = 16'h0000;
  localparam logic [1:0]  EVT_RST         = 2'h0;

  // Event bit positions.
  localparam int unsigned EVT_DONE_POS    = 0;
  localparam int unsigned EVT_LOST_POS    = 1;

  typedef enum logic [1:0] {
    PIT_FN_NONE  = 2'h0,
    PIT_FN_START = 2'h1,
    PIT_FN_CLEAR = 2'h2,
    PIT_FN_PULSE = 2'h3
  } pit_func_t;

  typedef enum logic [1:0] {
    PIT_RATE_OFF   = 2'h0,
    PIT_RATE_10HZ  = 2'h1,
    PIT_RATE_100HZ = 2'h2,
    PIT_RATE_1KHZ  = 2'h3
  } pit_rate_t;

  // Command word written at OFS_CMD, one programmed-I/O operation.
  typedef struct packed {
    logic [15:0] data;
    logic [6:0]  rsvd;
    logic        rate_load_output_op;
    pit_func_t   func;
    logic [5:0]  dev;
  } pit_cmd_t;

  // Status word read at OFS_STATUS.
  typedef struct packed {
    logic [26:0] rsvd;
    pit_rate_t   rate;
    logic        int_req;
    logic        done;
    logic        busy;
  } pit_status_t;

endpackage : pit_pkg

/* core/pit_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module pit_timer
  import pit_pkg::*;
#(
  parameter int unsigned BASE_TICK_CYCLES = BASE_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              bus_io_reset,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  output logic                   int_req,
  output logic                   irq
);

  logic              ack;
  logic              wr_go;
  pit_cmd_t          cmd;
  logic              cmd_hit;
  logic              do_start;
  logic              do_clear;
  logic              do_rate;
  pit_rate_t         rate;
  logic [15:0]       mask_out;
  logic              int_disable;
  logic [PRE_W-1:0]  pre_cnt;
  logic [3:0]        dec_10ms;
  logic [3:0]        dec_100ms;
  logic              tick_1ms;
  logic              tick_10ms;
  logic              tick_100ms;
  logic              tick;
  logic              busy;
  logic              done;
  logic [1:0]        evt_status;
  logic [1:0]        evt_mask;
  logic [1:0]        evt_set;
  logic [1:0]        evt_clr;
  pit_status_t       status;
  logic [31:0]       next_readdata;

  // Every access is answered on the second edge: the first edge latches read data and raises ack.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_go           = avs_write & ack;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack) begin
      avs_readdata <= next_readdata;
    end
  end

  always_comb begin
    status         = '0;
    status.busy    = busy;
    status.done    = done;
    status.int_req = int_req;
    status.rate    = rate;
    unique case (avs_address)
      OFS_STATUS:     next_readdata = status;
      OFS_MASK_OUT:   next_readdata = {16'h0000, mask_out};
      OFS_EVT_STATUS: next_readdata = {30'h0000_0000, evt_status};
      OFS_EVT_MASK:   next_readdata = {30'h0000_0000, evt_mask};
      default:        next_readdata = 32'h0000_0000;
    endcase
  end

  // Commands are only acted on when all four byte lanes are written, so a partial write cannot fire a half-formed operation.
  assign cmd      = pit_cmd_t'(avs_writedata);
  assign cmd_hit  = wr_go && (avs_address == OFS_CMD) && (&avs_byteenable) && (cmd.dev == OWN_DEV_CODE);
  assign do_start = cmd_hit && (cmd.func == PIT_FN_START);
  assign do_clear = cmd_hit && (cmd.func == PIT_FN_CLEAR);
  assign do_rate  = cmd_hit && cmd.rate_load_output_op;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rate <= PIT_RATE_OFF;
    end else if (bus_io_reset) begin
      rate <= PIT_RATE_OFF;
    end else if (do_rate) begin
      rate <= pit_rate_t'({cmd.data[1], cmd.data[0]});
    end
  end

  // Mask-out word uses bus bit numbering, bit 0 most significant.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mask_out <= MASK_OUT_RST;
    end else if (wr_go && avs_address == OFS_MASK_OUT) begin
      if (avs_byteenable[0]) mask_out[7:0]  <= avs_writedata[7:0];
      if (avs_byteenable[1]) mask_out[15:8] <= avs_writedata[15:8];
    end
  end
  assign int_disable = mask_out[MASK_BIT_POS];

  // Free-running divider; nothing but rst_b touches it, so Start never realigns the phase.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pre_cnt   <= '0;
      dec_10ms  <= 4'h0;
      dec_100ms <= 4'h0;
    end else begin
      pre_cnt <= tick_1ms ? '0 : pre_cnt + PRE_W'(1);
      if (tick_1ms) begin
        dec_10ms <= (dec_10ms == DECADE_LAST) ? 4'h0 : dec_10ms + 4'h1;
      end
      if (tick_10ms) begin
        dec_100ms <= (dec_100ms == DECADE_LAST) ? 4'h0 : dec_100ms + 4'h1;
      end
    end
  end

  assign tick_1ms   = (pre_cnt == PRE_W'(BASE_TICK_CYCLES - 1));
  assign tick_10ms  = tick_1ms && (dec_10ms == DECADE_LAST);
  assign tick_100ms = tick_10ms && (dec_100ms == DECADE_LAST);

  always_comb begin
    unique case (rate)
      PIT_RATE_OFF:   tick = 1'b0;
      PIT_RATE_10HZ:  tick = tick_100ms;
      PIT_RATE_100HZ: tick = tick_10ms;
      PIT_RATE_1KHZ:  tick = tick_1ms;
    endcase
  end

  // A Start in the same cycle as a tick wins: the new period is armed and that tick is lost.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy <= 1'b0;
      done <= 1'b0;
    end else if (bus_io_reset || do_clear) begin
      busy <= 1'b0;
      done <= 1'b0;
    end else if (do_start) begin
      busy <= 1'b1;
      done <= 1'b0;
    end else if (tick && busy) begin
      busy <= 1'b0;
      done <= 1'b1;
    end
  end

  assign int_req = done & ~int_disable;

  // Sticky events: completed period and tick dropped while not armed.
  assign evt_set[EVT_DONE_POS] = tick && busy && !do_start && !do_clear && !bus_io_reset;
  assign evt_set[EVT_LOST_POS] = tick && !busy;
  assign evt_clr = (wr_go && avs_address == OFS_EVT_STATUS && avs_byteenable[0]) ? avs_writedata[1:0] : 2'h0;

  // One sticky bit per event; a set in the same cycle as a write-one-to-clear wins, so no event is lost.
  for (genvar e = 0; e < 2; e++) begin : g_evt
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        evt_status[e] <= EVT_RST[e];
      end else if (evt_set[e]) begin
        evt_status[e] <= 1'b1;
      end else if (evt_clr[e]) begin
        evt_status[e] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      evt_mask <= EVT_RST;
    end else if (wr_go && avs_address == OFS_EVT_MASK && avs_byteenable[0]) begin
      evt_mask <= avs_writedata[1:0];
    end
  end

  assign irq = |(evt_status & evt_mask);

endmodule : pit_timer
`default_nettype wire

/* dv/pit_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module pit_host_model
  import pit_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              avs_waitrequest,
  input  wire logic [31:0]       avs_readdata,
  output logic      [ADDR_W-1:0] avs_address = 5'h00,
  output logic                   avs_read = 1'b0,
  output logic                   avs_write = 1'b0,
  output logic      [31:0]       avs_writedata = 32'h0,
  output logic      [3:0]        avs_byteenable = 4'hF
);
  // The idle edge after release keeps two requests from ever landing in one time step.
  task automatic xfer(input logic rd, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    @(posedge clk iff !avs_waitrequest);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : xfer
endmodule : pit_host_model
`default_nettype wire

/* dv/pit_timer_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module pit_timer_monitor
  import pit_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              bus_io_reset,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic              int_req,
  input wire logic              irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic rd_take = avs_read && avs_waitrequest;
  wire logic wr_done = avs_write && !avs_waitrequest && avs_byteenable == 4'hF;
  wire logic own_cmd = wr_done && avs_address == OFS_CMD && avs_writedata[5:0] == OWN_DEV_CODE;
  one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request waited more than one cycle");
  cmd_zero_a: assert property (rd_take && avs_address == OFS_CMD |=> avs_readdata == 32'h0)
    else $error("command word read back nonzero");
  status_irq_a: assert property (rd_take && avs_address == OFS_STATUS |=> avs_readdata[2] == $past(int_req))
    else $error("status request bit differs from pin");
  data_hold_a: assert property (avs_read && !avs_waitrequest |=> avs_readdata == $past(avs_readdata))
    else $error("read data changed after answer");
  io_reset_a: assert property (bus_io_reset |=> !int_req)
    else $error("request survived bus reset");
  clear_drop_a: assert property (own_cmd && avs_writedata[7:6] == PIT_FN_CLEAR |=> !int_req)
    else $error("request survived clear");
  mask_block_a: assert property (wr_done && avs_address == OFS_MASK_OUT && avs_writedata[MASK_BIT_POS] |=> !int_req)
    else $error("masked request still high");
  irq_gate_a: assert property (wr_done && avs_address == OFS_EVT_MASK && avs_writedata[1:0] == 2'h0 |=> !irq)
    else $error("irq high with all events masked");
endmodule : pit_timer_monitor
bind pit_timer pit_timer_monitor mon_u (.clk, .rst_b, .bus_io_reset, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .int_req, .irq);
`default_nettype wire

/* dv/test_pit_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module test_pit_timer
  import pit_pkg::*;
;
  localparam int unsigned TB = 20;
  logic clk = 1'b0, rst_b = 1'b0, bus_io_reset = 1'b0, int_req, irq, rd, wr, wq;
  logic [4:0] a;
  logic [31:0] wd, rdat, q;
  logic [3:0] be;
  logic [3:0] rows [4] = '{4'h0, 4'h5, 4'hA, 4'hF};
  int failures = 0, n_compared = 0, n;
  time t0;
  pit_timer #(.BASE_TICK_CYCLES(TB)) dut_u (.clk, .rst_b, .bus_io_reset, .avs_address(a), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wq),
    .int_req, .irq);
  pit_host_model host_u (.clk, .avs_waitrequest(wq), .avs_readdata(rdat), .avs_address(a), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be));
  initial forever #4 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cmd(input pit_func_t f, input logic ld, input logic [1:0] c, input logic [5:0] dv);
    host_u.xfer(1'b0, OFS_CMD, {14'h0, c, 7'h0, ld, f, dv}, q);
  endtask : cmd
  task automatic rdc(input logic [4:0] ad, input logic [31:0] e, input string nm);
    host_u.xfer(1'b1, ad, 32'h0, q);
    chk(nm, q, e);
  endtask : rdc
  task automatic wt();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (int_req !== 1'b1 && n < 4 * TB);
    @(posedge clk);
  endtask : wt
  task automatic end_sim();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  initial begin
    #100000;
    failures++;
    end_sim();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdc(OFS_STATUS, 32'h0, "reset status");
    for (int i = 0; i < 4; i++) begin
      cmd(PIT_FN_NONE, 1'b1, rows[i][3:2], OWN_DEV_CODE);
      rdc(OFS_STATUS, {27'h0, rows[i][1:0], 3'h0}, "rate");
    end
    rdc(5'h14, 32'h0, "unmapped");
    rdc(OFS_CMD, 32'h0, "cmd read");
    host_u.xfer(1'b0, OFS_EVT_MASK, 32'h1, q);
    cmd(PIT_FN_START, 1'b0, 2'h0, 6'h0D);
    rdc(OFS_STATUS, 32'h18, "foreign code");
    cmd(PIT_FN_START, 1'b0, 2'h0, OWN_DEV_CODE);
    wt();
    chk("first tick", n <= TB, 1'b1);
    t0 = $time;
    cmd(PIT_FN_START, 1'b0, 2'h0, OWN_DEV_CODE);
    wt();
    chk("period", ($time - t0) / CLK_PERIOD_NS, TB);
    chk("irq", irq, 1'b1);
    host_u.xfer(1'b0, OFS_MASK_OUT, 32'h4, q);
    rdc(OFS_STATUS, 32'h1A, "masked");
    repeat (2 * TB) @(posedge clk);
    host_u.xfer(1'b0, OFS_EVT_STATUS, 32'h1, q);
    chk("lost tick", irq, 1'b0);
    rdc(OFS_EVT_STATUS, 32'h2, "lost event");
    host_u.xfer(1'b0, OFS_EVT_MASK, 32'h0, q);
    cmd(PIT_FN_CLEAR, 1'b0, 2'h0, OWN_DEV_CODE);
    rdc(OFS_STATUS, 32'h18, "clear");
    bus_io_reset <= 1'b1;
    @(posedge clk);
    bus_io_reset <= 1'b0;
    @(posedge clk);
    cmd(PIT_FN_START, 1'b0, 2'h0, OWN_DEV_CODE);
    repeat (2 * TB) @(posedge clk);
    rdc(OFS_STATUS, 32'h1, "io reset");
    end_sim();
  end
endmodule : test_pit_timer
`default_nettype wire
